// ---- design/isr_consts.vh ----
// isr_consts.vh: bit positions, reset values and register selectors of the status block
// assumes inclusion by every design file of the block
`ifndef ISR_CONSTS_VH
`define ISR_CONSTS_VH
// operation condition bits
`define ISR_OPERATION_SUMMARY_MEAS_ACTIVE 4
`define ISR_OPERATION_SUMMARY_MEAS_ARMED 5
`define ISR_OPERATION_SUMMARY_SEQ_BUSY 6
`define ISR_OPERATION_SUMMARY_SEQ_WAIT 7
`define ISR_OPERATION_SUMMARY_CONST_VOLT 8
`define ISR_OPERATION_SUMMARY_SOFT_START 9
`define ISR_OPERATION_SUMMARY_SYNC_ON 10
`define ISR_OPERATION_SUMMARY_INST_SUM 13
// questionable condition bits
`define ISR_ABNORMAL_SUMMARY_HIGH_VOLT 0
`define ISR_ABNORMAL_SUMMARY_EXCESS_CUR 1
`define ISR_ABNORMAL_SUMMARY_HW_FAULT 2
`define ISR_ABNORMAL_SUMMARY_UNDERVOLT 3
`define ISR_ABNORMAL_SUMMARY_THERMAL 4
`define ISR_ABNORMAL_SUMMARY_IO_INACT 5
`define ISR_ABNORMAL_SUMMARY_SEMI_CUR 6
`define ISR_ABNORMAL_SUMMARY_FREQ_LOCK 7
`define ISR_ABNORMAL_SUMMARY_OVERPOWER 8
`define ISR_ABNORMAL_SUMMARY_SHUTDOWN 9
`define ISR_ABNORMAL_SUMMARY_PEAK_LIM 10
`define ISR_ABNORMAL_SUMMARY_POWER_LIM 11
`define ISR_ABNORMAL_SUMMARY_RMS_LIM 12
`define ISR_ABNORMAL_SUMMARY_INST_SUM 13
// valid bit masks of the 16-bit groups
`define ISR_OPERATION_SUMMARY_USED_MASK 16'h27f0
`define ISR_ABNORMAL_SUMMARY_USED_MASK 16'h3fff
// common event bits
`define ISR_ESR_OP_DONE 0
`define ISR_ESR_QUERY_ERR 2
`define ISR_ESR_DEV_ERR 3
`define ISR_ESR_EXEC_ERR 4
`define ISR_ESR_CMD_ERR 5
`define ISR_ESR_POWER_ON 7
`define ISR_ESR_USED_MASK 8'hbd
`define ISR_ESR_RESET 8'h80
// status byte bits
`define ISR_STB_ERRQ 2
`define ISR_STB_ABNORMAL_SUMMARY 3
`define ISR_STB_MAV 4
`define ISR_STB_ESB 5
`define ISR_STB_RQS 6
`define ISR_STB_OPERATION_SUMMARY 7
`define ISR_SRE_MASK 8'hbf
// group register selectors
`define ISR_GSEL_COND 3'h0
`define ISR_GSEL_EVENT 3'h1
`define ISR_GSEL_ENABLE 3'h2
`define ISR_GSEL_PTR 3'h3
`define ISR_GSEL_NTR 3'h4
// group reset values
`define ISR_G16_ZERO 16'h0000
`define ISR_PTR_RESET 16'hffff
`define ISR_B8_ZERO 8'h00
`endif

// ---- design/isr_edge_bit.v ----
// isr_edge_bit.v: one condition bit with transition filter and latched event
// assumes single clock, clock enable and async high reset
`timescale 1ns/1ps
`include "isr_consts.vh"
module isr_edge_bit (
  input wire ref_clk_in,
  input wire reset_in,
  input wire clk_en_in,
  input wire cond_in,
  input wire ptr_in,
  input wire ntr_in,
  input wire clear_in,
  output wire event_out
);
  reg cond_r;
  reg event_r;
  wire rise;
  wire fall;
  wire hit;
  assign rise = cond_in & ~cond_r;
  assign fall = ~cond_in & cond_r;
  assign hit = (rise & ptr_in) | (fall & ntr_in);
  assign event_out = event_r;
  always @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      cond_r <= 1'b0;
      event_r <= 1'b0;
    end else if (clk_en_in) begin
      cond_r <= cond_in;
      event_r <= hit | (event_r & ~clear_in);
    end
  end
endmodule // isr_edge_bit

// ---- design/isr_group16.v ----
// isr_group16.v: 16-bit condition, filter, event and enable group
// assumes host writes filters and enable through the top-level port
`timescale 1ns/1ps
`include "isr_consts.vh"
module isr_group16 #(
  parameter [15:0] USED_MASK = 16'hffff
) (
  input wire ref_clk_in,
  input wire reset_in,
  input wire clk_en_in,
  input wire [15:0] cond_in,
  input wire wr_in,
  input wire rd_in,
  input wire [2:0] sel_in,
  input wire [15:0] wdata_in,
  output reg [15:0] rdata_out,
  output wire summary_out
);
  reg [15:0] ptr_r;
  reg [15:0] ntr_r;
  reg [15:0] enable_r;
  wire [15:0] cond_m;
  wire [15:0] event_w;
  wire clear_ev;
  assign cond_m = cond_in & USED_MASK;
  assign clear_ev = rd_in & (sel_in == `ISR_GSEL_EVENT);
  genvar i;
  generate
    for (i = 0; i < 16; i = i + 1) begin : g_bit
      isr_edge_bit u_bit (
        .ref_clk_in(ref_clk_in),
        .reset_in(reset_in),
        .clk_en_in(clk_en_in),
        .cond_in(cond_m[i]),
        .ptr_in(ptr_r[i]),
        .ntr_in(ntr_r[i]),
        .clear_in(clear_ev),
        .event_out(event_w[i])
      );
    end
  endgenerate
  assign summary_out = |(event_w & enable_r);
  always @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      ptr_r <= `ISR_PTR_RESET & USED_MASK;
      ntr_r <= `ISR_G16_ZERO;
      enable_r <= `ISR_G16_ZERO;
      rdata_out <= `ISR_G16_ZERO;
    end else if (clk_en_in) begin
      if (wr_in) begin
        case (sel_in)
          `ISR_GSEL_ENABLE: enable_r <= wdata_in & USED_MASK;
          `ISR_GSEL_PTR: ptr_r <= wdata_in & USED_MASK;
          `ISR_GSEL_NTR: ntr_r <= wdata_in & USED_MASK;
          default: ;
        endcase
      end
      if (rd_in) begin
        case (sel_in)
          `ISR_GSEL_COND: rdata_out <= cond_m;
          `ISR_GSEL_EVENT: rdata_out <= event_w;
          `ISR_GSEL_ENABLE: rdata_out <= enable_r;
          `ISR_GSEL_PTR: rdata_out <= ptr_r;
          `ISR_GSEL_NTR: rdata_out <= ntr_r;
          default: rdata_out <= `ISR_G16_ZERO;
        endcase
      end
    end
  end
endmodule // isr_group16

// ---- design/isr_status_top.v ----
// isr_status_top.v: status reporting of a three-phase source
// assumes command decoder gives one-cycle strobes synchronous to ref_clk_in
`timescale 1ns/1ps
`include "isr_consts.vh"
module isr_status_top (
  input wire ref_clk_in,
  input wire reset_in,
  input wire clk_en_in,
  input wire measurement_active_in,
  input wire measurement_armed_in,
  input wire seq_busy_in,
  input wire seq_waiting_in,
  input wire constant_voltage_mode_in,
  input wire soft_start_active_in,
  input wire sync_active_in,
  input wire operation_summary_inst_summary_in,
  input wire high_voltage_trip_in,
  input wire excess_current_trip_in,
  input wire hardware_fault_in,
  input wire undervoltage_seen_in,
  input wire thermal_trip_in,
  input wire io_inactivity_trip_in,
  input wire semiconductor_current_trip_in,
  input wire frequency_lock_error_in,
  input wire overpower_trip_in,
  input wire forced_shutdown_in,
  input wire peak_current_limit_in,
  input wire power_limit_in,
  input wire rms_current_limit_in,
  input wire abnormal_summary_inst_summary_in,
  input wire op_complete_in,
  input wire query_error_in,
  input wire device_error_in,
  input wire exec_error_in,
  input wire command_error_in,
  input wire error_queue_nonempty_in,
  input wire output_data_waiting_in,
  input wire operation_summary_wr_in,
  input wire operation_summary_rd_in,
  input wire abnormal_summary_wr_in,
  input wire abnormal_summary_rd_in,
  input wire [2:0] grp_sel_in,
  input wire [15:0] grp_wdata_in,
  input wire esr_rd_in,
  input wire cls_in,
  input wire ese_wr_in,
  input wire sre_wr_in,
  input wire [7:0] mask_wdata_in,
  input wire stb_query_in,
  input wire serial_poll_in,
  output wire [15:0] operation_summary_rdata_out,
  output wire [15:0] abnormal_summary_rdata_out,
  output reg [7:0] esr_rdata_out,
  output reg [7:0] ese_out,
  output reg [7:0] sre_out,
  output reg [7:0] stb_rdata_out,
  output reg [7:0] poll_rdata_out,
  output wire srq_out
);
  reg [7:0] esr_r;
  reg [7:0] esr_nxt;
  reg rqs_r;
  reg [7:0] esr_set;
  reg [15:0] operation_summary_cond;
  reg [15:0] abnormal_summary_cond;
  reg [7:0] stb_base;
  wire operation_summary;
  wire abnormal_summary;
  wire esb;
  wire mss;
  wire [7:0] stb_full;
  reg mss_d_r;
  // operation condition map
  always @* begin
    operation_summary_cond = `ISR_G16_ZERO;
    operation_summary_cond[`ISR_OPERATION_SUMMARY_MEAS_ACTIVE] = measurement_active_in;
    operation_summary_cond[`ISR_OPERATION_SUMMARY_MEAS_ARMED] = measurement_armed_in;
    operation_summary_cond[`ISR_OPERATION_SUMMARY_SEQ_BUSY] = seq_busy_in;
    operation_summary_cond[`ISR_OPERATION_SUMMARY_SEQ_WAIT] = seq_waiting_in;
    operation_summary_cond[`ISR_OPERATION_SUMMARY_CONST_VOLT] = constant_voltage_mode_in;
    operation_summary_cond[`ISR_OPERATION_SUMMARY_SOFT_START] = soft_start_active_in;
    operation_summary_cond[`ISR_OPERATION_SUMMARY_SYNC_ON] = sync_active_in;
    operation_summary_cond[`ISR_OPERATION_SUMMARY_INST_SUM] = operation_summary_inst_summary_in;
  end
  // questionable condition map
  always @* begin
    abnormal_summary_cond = `ISR_G16_ZERO;
    abnormal_summary_cond[`ISR_ABNORMAL_SUMMARY_HIGH_VOLT] = high_voltage_trip_in;
    abnormal_summary_cond[`ISR_ABNORMAL_SUMMARY_EXCESS_CUR] = excess_current_trip_in;
    abnormal_summary_cond[`ISR_ABNORMAL_SUMMARY_HW_FAULT] = hardware_fault_in;
    abnormal_summary_cond[`ISR_ABNORMAL_SUMMARY_UNDERVOLT] = undervoltage_seen_in;
    abnormal_summary_cond[`ISR_ABNORMAL_SUMMARY_THERMAL] = thermal_trip_in;
    abnormal_summary_cond[`ISR_ABNORMAL_SUMMARY_IO_INACT] = io_inactivity_trip_in;
    abnormal_summary_cond[`ISR_ABNORMAL_SUMMARY_SEMI_CUR] = semiconductor_current_trip_in;
    abnormal_summary_cond[`ISR_ABNORMAL_SUMMARY_FREQ_LOCK] = frequency_lock_error_in;
    abnormal_summary_cond[`ISR_ABNORMAL_SUMMARY_OVERPOWER] = overpower_trip_in;
    abnormal_summary_cond[`ISR_ABNORMAL_SUMMARY_SHUTDOWN] = forced_shutdown_in;
    abnormal_summary_cond[`ISR_ABNORMAL_SUMMARY_PEAK_LIM] = peak_current_limit_in;
    abnormal_summary_cond[`ISR_ABNORMAL_SUMMARY_POWER_LIM] = power_limit_in;
    abnormal_summary_cond[`ISR_ABNORMAL_SUMMARY_RMS_LIM] = rms_current_limit_in;
    abnormal_summary_cond[`ISR_ABNORMAL_SUMMARY_INST_SUM] = abnormal_summary_inst_summary_in;
  end
  isr_group16 #(
    .USED_MASK(`ISR_OPERATION_SUMMARY_USED_MASK)
  ) u_operation_summary (
    .ref_clk_in(ref_clk_in),
    .reset_in(reset_in),
    .clk_en_in(clk_en_in),
    .cond_in(operation_summary_cond),
    .wr_in(operation_summary_wr_in),
    .rd_in(operation_summary_rd_in),
    .sel_in(grp_sel_in),
    .wdata_in(grp_wdata_in),
    .rdata_out(operation_summary_rdata_out),
    .summary_out(operation_summary)
  );
  isr_group16 #(
    .USED_MASK(`ISR_ABNORMAL_SUMMARY_USED_MASK)
  ) u_abnormal_summary (
    .ref_clk_in(ref_clk_in),
    .reset_in(reset_in),
    .clk_en_in(clk_en_in),
    .cond_in(abnormal_summary_cond),
    .wr_in(abnormal_summary_wr_in),
    .rd_in(abnormal_summary_rd_in),
    .sel_in(grp_sel_in),
    .wdata_in(grp_wdata_in),
    .rdata_out(abnormal_summary_rdata_out),
    .summary_out(abnormal_summary)
  );
  // common event sets
  always @* begin
    esr_set = `ISR_B8_ZERO;
    esr_set[`ISR_ESR_OP_DONE] = op_complete_in;
    esr_set[`ISR_ESR_QUERY_ERR] = query_error_in;
    esr_set[`ISR_ESR_DEV_ERR] = device_error_in;
    esr_set[`ISR_ESR_EXEC_ERR] = exec_error_in;
    esr_set[`ISR_ESR_CMD_ERR] = command_error_in;
    esr_nxt = esr_r;
    if (esr_rd_in | cls_in) begin
      esr_nxt = `ISR_B8_ZERO;
    end
    esr_nxt = esr_nxt | esr_set; // set wins over clear
  end
  assign esb = |(esr_r & ese_out);
  // status byte without bit 6
  always @* begin
    stb_base = `ISR_B8_ZERO;
    stb_base[`ISR_STB_ERRQ] = error_queue_nonempty_in;
    stb_base[`ISR_STB_ABNORMAL_SUMMARY] = abnormal_summary;
    stb_base[`ISR_STB_MAV] = output_data_waiting_in;
    stb_base[`ISR_STB_ESB] = esb;
    stb_base[`ISR_STB_OPERATION_SUMMARY] = operation_summary;
  end
  assign mss = |(stb_base & sre_out);
  assign stb_full = stb_base | ({7'h00, mss} << `ISR_STB_RQS);
  assign srq_out = rqs_r;
  always @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      esr_r <= `ISR_ESR_RESET;
      ese_out <= `ISR_B8_ZERO;
      sre_out <= `ISR_B8_ZERO;
      esr_rdata_out <= `ISR_B8_ZERO;
      stb_rdata_out <= `ISR_B8_ZERO;
      poll_rdata_out <= `ISR_B8_ZERO;
      rqs_r <= 1'b0;
      mss_d_r <= 1'b0;
    end else if (clk_en_in) begin
      esr_r <= esr_nxt;
      mss_d_r <= mss;
      if (esr_rd_in) begin
        esr_rdata_out <= esr_r;
      end
      if (ese_wr_in) begin
        ese_out <= mask_wdata_in & `ISR_ESR_USED_MASK;
      end
      if (sre_wr_in) begin
        sre_out <= mask_wdata_in & `ISR_SRE_MASK;
      end
      if (stb_query_in) begin
        stb_rdata_out <= stb_full;
      end
      if (serial_poll_in) begin
        poll_rdata_out <= stb_base | ({7'h00, rqs_r} << `ISR_STB_RQS);
      end
      // new request on rising summary wins over the poll clear
      if (mss & ~mss_d_r) begin
        rqs_r <= 1'b1;
      end else if (serial_poll_in) begin
        rqs_r <= 1'b0;
      end
    end
  end
endmodule // isr_status_top

// ---- testbench/isr_status_monitor.sv ----
// isr_status_monitor.sv: port assertions of the status block
// assumes bind to isr_status_top, single clock domain
`timescale 1ns/1ps
`include "isr_consts.vh"
module isr_status_monitor (
  input wire ref_clk_in,
  input wire reset_in,
  input wire clk_en_in,
  input wire error_queue_nonempty_in,
  input wire output_data_waiting_in,
  input wire ese_wr_in,
  input wire sre_wr_in,
  input wire [7:0] mask_wdata_in,
  input wire stb_query_in,
  input wire serial_poll_in,
  input wire [15:0] operation_summary_rdata_out,
  input wire [15:0] abnormal_summary_rdata_out,
  input wire [7:0] esr_rdata_out,
  input wire [7:0] ese_out,
  input wire [7:0] sre_out,
  input wire [7:0] stb_rdata_out,
  input wire [7:0] poll_rdata_out,
  input wire srq_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);
  sequence s_query; clk_en_in && stb_query_in; endsequence
  sequence s_poll; clk_en_in && serial_poll_in && srq_out; endsequence
  property p_operation_summary_rsv; (operation_summary_rdata_out & ~`ISR_OPERATION_SUMMARY_USED_MASK) == 16'h0000; endproperty
  property p_abnormal_summary_rsv; (abnormal_summary_rdata_out & ~`ISR_ABNORMAL_SUMMARY_USED_MASK) == 16'h0000; endproperty
  property p_byte_rsv;
    esr_rdata_out[6] == 1'b0 && esr_rdata_out[1] == 1'b0 && stb_rdata_out[1:0] == 2'b00;
  endproperty
  property p_errq; s_query |=> stb_rdata_out[2] == $past(error_queue_nonempty_in); endproperty
  property p_mav; s_query |=> stb_rdata_out[4] == $past(output_data_waiting_in); endproperty
  property p_mss;
    s_query |=> stb_rdata_out[6] == |(stb_rdata_out & $past(sre_out) & 8'hbf);
  endproperty
  property p_query_keep; s_query ##0 (srq_out && !serial_poll_in) |=> srq_out; endproperty
  property p_poll; s_poll |=> poll_rdata_out[6] && !srq_out; endproperty
  property p_sre; clk_en_in && sre_wr_in |=> sre_out == ($past(mask_wdata_in) & 8'hbf); endproperty
  property p_ese; clk_en_in && ese_wr_in |=> ese_out == ($past(mask_wdata_in) & 8'hbd); endproperty
  a_operation_summary_rsv: assert property (p_operation_summary_rsv) else $error("operation_summary spare bit set");
  a_abnormal_summary_rsv: assert property (p_abnormal_summary_rsv) else $error("abnormal_summary spare bit set");
  a_byte_rsv: assert property (p_byte_rsv) else $error("byte spare bit set");
  a_errq: assert property (p_errq) else $error("error queue bit wrong");
  a_mav: assert property (p_mav) else $error("message bit wrong");
  a_mss: assert property (p_mss) else $error("summary bit wrong");
  a_query_keep: assert property (p_query_keep) else $error("query dropped request");
  a_poll: assert property (p_poll) else $error("poll result wrong");
  a_sre: assert property (p_sre) else $error("request mask wrong");
  a_ese: assert property (p_ese) else $error("event mask wrong");
endmodule // isr_status_monitor
bind isr_status_top isr_status_monitor u_mon (.ref_clk_in, .reset_in, .clk_en_in,
  .error_queue_nonempty_in, .output_data_waiting_in, .ese_wr_in, .sre_wr_in,
  .mask_wdata_in, .stb_query_in, .serial_poll_in, .operation_summary_rdata_out, .abnormal_summary_rdata_out,
  .esr_rdata_out, .ese_out, .sre_out, .stb_rdata_out, .poll_rdata_out, .srq_out);

// ---- testbench/isr_ctrl_model.sv ----
// isr_ctrl_model.sv: remote controller answering service requests by serial poll
// assumes request line registered on the same clock
`timescale 1ns/1ps
module isr_ctrl_model (
  input wire ref_clk_in,
  input wire reset_in,
  input wire srq_in,
  input wire slow_in,
  output logic serial_poll_out
);
  int cnt;
  // one poll per request, prompt or after six cycles
  always @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      serial_poll_out <= 1'b0;
      cnt <= 0;
    end else if (serial_poll_out || !srq_in) begin
      serial_poll_out <= 1'b0;
      cnt <= 0;
    end else if (cnt == (slow_in ? 6 : 0)) begin
      serial_poll_out <= 1'b1;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule // isr_ctrl_model

// ---- testbench/isr_status_tb_top.sv ----
// isr_status_tb_top.sv: self-checking bench of the status block
// assumes a 100 MHz clock and a polling controller model
`timescale 1ns/1ps
`include "isr_consts.vh"
module isr_status_tb_top;
  logic ref_clk_in, reset_in, clk_en_in, error_queue_nonempty_in, output_data_waiting_in;
  logic operation_summary_wr_in, operation_summary_rd_in, abnormal_summary_wr_in, abnormal_summary_rd_in, serial_poll_in, srq_out, slow;
  logic [2:0] grp_sel_in;
  logic [15:0] grp_wdata_in, oc, qc, operation_summary_rdata_out, abnormal_summary_rdata_out;
  logic [7:0] mask_wdata_in, esr_rdata_out, ese_out, sre_out, stb_rdata_out, poll_rdata_out;
  logic [5:0] ev;
  logic [4:0] bs;
  int fails, comparisons;
  isr_status_top dut (.ref_clk_in(ref_clk_in), .reset_in(reset_in), .clk_en_in(clk_en_in),
    .error_queue_nonempty_in(error_queue_nonempty_in),
    .output_data_waiting_in(output_data_waiting_in), .operation_summary_wr_in(operation_summary_wr_in),
    .operation_summary_rd_in(operation_summary_rd_in), .abnormal_summary_wr_in(abnormal_summary_wr_in), .abnormal_summary_rd_in(abnormal_summary_rd_in),
    .grp_sel_in(grp_sel_in), .grp_wdata_in(grp_wdata_in), .mask_wdata_in(mask_wdata_in),
    .serial_poll_in(serial_poll_in), .operation_summary_rdata_out(operation_summary_rdata_out),
    .abnormal_summary_rdata_out(abnormal_summary_rdata_out), .esr_rdata_out(esr_rdata_out), .ese_out(ese_out),
    .sre_out(sre_out), .stb_rdata_out(stb_rdata_out), .poll_rdata_out(poll_rdata_out),
    .srq_out(srq_out),
    .measurement_active_in(oc[4]), .measurement_armed_in(oc[5]), .seq_busy_in(oc[6]),
    .seq_waiting_in(oc[7]), .constant_voltage_mode_in(oc[8]), .soft_start_active_in(oc[9]),
    .sync_active_in(oc[10]), .operation_summary_inst_summary_in(oc[13]), .high_voltage_trip_in(qc[0]),
    .excess_current_trip_in(qc[1]), .hardware_fault_in(qc[2]), .undervoltage_seen_in(qc[3]),
    .thermal_trip_in(qc[4]), .io_inactivity_trip_in(qc[5]),
    .semiconductor_current_trip_in(qc[6]), .frequency_lock_error_in(qc[7]),
    .overpower_trip_in(qc[8]), .forced_shutdown_in(qc[9]), .peak_current_limit_in(qc[10]),
    .power_limit_in(qc[11]), .rms_current_limit_in(qc[12]), .abnormal_summary_inst_summary_in(qc[13]),
    .op_complete_in(ev[0]), .query_error_in(ev[2]), .device_error_in(ev[3]),
    .exec_error_in(ev[4]), .command_error_in(ev[5]), .esr_rd_in(bs[0]), .ese_wr_in(bs[1]),
    .sre_wr_in(bs[2]), .stb_query_in(bs[3]), .cls_in(bs[4]));
  isr_ctrl_model ctrl (.ref_clk_in(ref_clk_in), .reset_in(reset_in), .srq_in(srq_out),
    .slow_in(slow), .serial_poll_out(serial_poll_in));
  initial begin
    ref_clk_in = 1'b0;
    forever #5 ref_clk_in = ~ref_clk_in;
  end
  task automatic give_verdict;
    $display("comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    chk16({8'h00, got}, {8'h00, exp});
  endtask
  // group access: q picks the group, w writes d, else reads and expects d
  task automatic acc(input bit q, input bit w, input logic [2:0] s, input logic [15:0] d);
    @(posedge ref_clk_in);
    {abnormal_summary_wr_in, operation_summary_wr_in} <= w ? {q, !q} : 2'b00;
    {abnormal_summary_rd_in, operation_summary_rd_in} <= w ? 2'b00 : {q, !q};
    grp_sel_in <= s;
    grp_wdata_in <= d;
    @(posedge ref_clk_in);
    {abnormal_summary_wr_in, operation_summary_wr_in, abnormal_summary_rd_in, operation_summary_rd_in} <= 4'h0;
    @(negedge ref_clk_in);
    if (!w) chk16(q ? abnormal_summary_rdata_out : operation_summary_rdata_out, d);
  endtask
  // byte command: 0 esr read, 1 ese write, 2 sre write, 3 query, 4 clear
  task automatic cmd(input int k, input logic [7:0] m);
    @(posedge ref_clk_in);
    bs <= 5'b00001 << k;
    mask_wdata_in <= m;
    @(posedge ref_clk_in);
    bs <= 5'b00000;
    @(negedge ref_clk_in);
  endtask
  task automatic setc(input bit q, input logic [15:0] v);
    @(posedge ref_clk_in);
    if (q) qc <= v;
    else oc <= v;
    repeat (2) @(posedge ref_clk_in);
  endtask
  task automatic pulse(input logic [5:0] v);
    @(posedge ref_clk_in);
    ev <= v;
    @(posedge ref_clk_in);
    ev <= 6'h00;
  endtask
  // waits for the controller's poll, then one cycle for its result
  task automatic wait_poll;
    for (int n = 0; n < 20 && !serial_poll_in; n++) @(negedge ref_clk_in);
    @(negedge ref_clk_in);
  endtask
  initial begin
    #50000;
    fails++;
    give_verdict();
  end
  initial begin
    logic [15:0] e;
    {reset_in, clk_en_in, error_queue_nonempty_in, output_data_waiting_in} = 4'b1100;
    {operation_summary_wr_in, operation_summary_rd_in, abnormal_summary_wr_in, abnormal_summary_rd_in, slow} = 5'b00000;
    {grp_sel_in, grp_wdata_in, oc, qc, mask_wdata_in, ev, bs} = '0;
    repeat (10) @(posedge ref_clk_in);
    reset_in <= 1'b0;
    cmd(0, 8'h00);
    chk8(esr_rdata_out, 8'h80);
    cmd(0, 8'h00);
    chk8(esr_rdata_out, 8'h00);
    for (int g = 0; g < 2; g++) begin
      for (int i = 0; i < 16; i++) begin
        e = (16'h0001 << i) & (g ? `ISR_ABNORMAL_SUMMARY_USED_MASK : `ISR_OPERATION_SUMMARY_USED_MASK);
        setc(g, 16'h0001 << i);
        acc(g, 0, `ISR_GSEL_COND, e);
        acc(g, 0, `ISR_GSEL_EVENT, e);
        setc(g, 16'h0000);
        acc(g, 0, `ISR_GSEL_EVENT, 16'h0000);
      end
    end
    acc(1, 1, `ISR_GSEL_PTR, 16'h0000);
    acc(1, 1, `ISR_GSEL_NTR, 16'hffff);
    setc(1, 16'h1000);
    setc(1, 16'h0000);
    setc(1, 16'h1000);
    acc(1, 0, `ISR_GSEL_EVENT, 16'h1000);
    acc(1, 1, `ISR_GSEL_NTR, 16'h0000);
    acc(1, 1, `ISR_GSEL_PTR, 16'hffff);
    acc(1, 0, `ISR_GSEL_PTR, `ISR_ABNORMAL_SUMMARY_USED_MASK);
    setc(1, 16'h0000);
    slow <= 1'b1;
    cmd(2, 8'h88);
    chk8(sre_out, 8'h88);
    setc(1, 16'h0001);
    cmd(3, 8'h00);
    chk8(stb_rdata_out, 8'h00);
    acc(1, 1, `ISR_GSEL_ENABLE, 16'h0001);
    cmd(3, 8'h00);
    chk8(stb_rdata_out, 8'h48);
    chk8({7'h00, srq_out}, 8'h01);
    wait_poll();
    chk8(poll_rdata_out, 8'h48);
    chk8({7'h00, srq_out}, 8'h00);
    acc(1, 0, `ISR_GSEL_EVENT, 16'h0001);
    slow <= 1'b0;
    setc(0, 16'h0010);
    acc(0, 1, `ISR_GSEL_ENABLE, 16'h0010);
    cmd(3, 8'h00);
    chk8(stb_rdata_out, 8'hc0);
    wait_poll();
    chk8(poll_rdata_out, 8'hc0);
    chk8({7'h00, srq_out}, 8'h00);
    cmd(2, 8'hff);
    chk8(sre_out, 8'hbf);
    cmd(2, 8'h00);
    cmd(1, 8'hff);
    chk8(ese_out, 8'hbd);
    @(posedge ref_clk_in);
    error_queue_nonempty_in <= 1'b1;
    output_data_waiting_in <= 1'b1;
    pulse(6'h3d);
    cmd(3, 8'h00);
    chk8(stb_rdata_out, 8'hb4);
    cmd(0, 8'h00);
    chk8(esr_rdata_out, 8'h3d);
    cmd(3, 8'h00);
    chk8(stb_rdata_out, 8'h94);
    pulse(6'h01);
    cmd(4, 8'h00);
    cmd(0, 8'h00);
    chk8(esr_rdata_out, 8'h00);
    // frozen by clock enable: the event must not land
    @(posedge ref_clk_in);
    clk_en_in <= 1'b0;
    pulse(6'h08);
    clk_en_in <= 1'b1;
    cmd(0, 8'h00);
    chk8(esr_rdata_out, 8'h00);
    @(posedge ref_clk_in);
    reset_in <= 1'b1;
    repeat (3) @(posedge ref_clk_in);
    reset_in <= 1'b0;
    cmd(0, 8'h00);
    chk8(esr_rdata_out, 8'h80);
    give_verdict();
  end
endmodule // isr_status_tb_top
